// ### rtl/pms_regs.svh
// register map, field positions, reset values and word lengths of the
// pager message serial output; assumes 32-bit word-aligned register access
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

// =====================================================================
// register byte offsets
`define PMS_OFS_CFG     8'h00
`define PMS_OFS_CALL    8'h04
`define PMS_OFS_MSG     8'h08
`define PMS_OFS_END     8'h0C
`define PMS_OFS_STATUS  8'h10

// =====================================================================
// configuration fields
`define PMS_CFG_BURST   0
`define PMS_CFG_OVA     1
`define PMS_CFG_OVB     2
`define PMS_CFG_USER    3
`define PMS_CFG_DBL     4
`define PMS_CFG_RESET   5'h00

// =====================================================================
// call and end fields
`define PMS_CALL_RICB   0
`define PMS_CALL_FC1    20
`define PMS_CALL_FC2    21
`define PMS_END_OK      0

// =====================================================================
// word lengths in link bits
`define PMS_LEN_CMD     5'h08
`define PMS_LEN_MSG     5'h18

`endif

// ### rtl/pms_pkg.sv
// types shared by the pager message serial output
// assumes nothing of its surroundings
package pms_pkg;

  // link sequencer states
  typedef enum logic [1:0] {
    PMS_L_IDLE,
    PMS_L_LOW,
    PMS_L_HIGH
  } pms_link_st_t;

endpackage

// ### rtl/pms_serial_out.sv
// pager message serial output: AHB-Lite register slave on hclk and a
// bit-serial framer on link_clk that drives data and its strobe.
// assumes hready is the bus's hready (this slave's hreadyout) and that
// link_clk runs free.
//
// Notes on behaviour
// - A write of the call register starts a transfer with a start word at once.
// - The start word has 8 bits with bit 0 low and bit 1 high.
// - Start bits 2, 3, 4 carry the burst, address-A and address-B settings.
// - Start bit 5 is 0 for the first receiver code and 1 for the second.
// - Start bits 6 and 7 carry codeword bits 20 and 21 of the call.
// - Each message codeword written afterwards goes out as one 24-bit word.
// - A message word has bits 0..3 high and bits 4..23 from codeword bits 2..21.
// - A transfer ends with an 8-bit stop word whose bits 0 and 1 are low.
// - Stop bit 2 is 1 for a proper end and 0 for an uncorrectable codeword.
// - Stop bit 3 is the inverse of the vibrator enable input.
// - Stop bits 4 and 5 carry the user and doubler settings, bits 6, 7 are zero.
// - A new call may follow without a stop word, its start word closing the last.
// - The device drives the strobe by which the receiver clocks each bit.
// - Burst correction applies on the second code with function 00 or 11 if enabled.
`timescale 1ns/10ps
`default_nettype none
`include "pms_regs.svh"

module pms_serial_out (
  // clocks and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        link_clk,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // pins
  input  wire logic        vib_enable,
  output logic             ser_data,
  output logic             ser_strobe,
  output logic             corr_burst4
);
  import pms_pkg::*;

  // ===================================================================
  // helpers
  function automatic logic is_cmd(input logic [7:0] a);
    is_cmd = (a == `PMS_OFS_CALL) || (a == `PMS_OFS_MSG) ||
             (a == `PMS_OFS_END);
  endfunction

  // ===================================================================
  // bus address phase
  logic [7:0]  addr_ff;
  logic        wr_ff;
  logic        valid_ff;
  logic [31:0] rdata_ff;
  logic [4:0]  cfg_ff;
  logic        busy_ff;
  logic        in_call_ff;
  logic        burst4_ff;
  logic        vib_s1_ff;
  logic        vib_s2_ff;
  logic        take;
  logic        wr_go;
  logic        go_call;
  logic        go_msg;
  logic        go_end;

  assign take  = hsel && hready && htrans[1];
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  // command writes wait while a word is still on the link
  assign hreadyout = !(valid_ff && wr_ff && is_cmd(addr_ff) && busy_ff);
  assign wr_go   = valid_ff && wr_ff && hreadyout;
  assign go_call = wr_go && (addr_ff == `PMS_OFS_CALL);
  assign go_msg  = wr_go && (addr_ff == `PMS_OFS_MSG);
  assign go_end  = wr_go && (addr_ff == `PMS_OFS_END);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff  <= 8'h00;
      wr_ff    <= 1'b0;
      valid_ff <= 1'b0;
    end else if (hready) begin
      addr_ff  <= haddr[7:0];
      wr_ff    <= hwrite;
      valid_ff <= take && (haddr[31:8] == 24'h000000);
    end
  end

  // read data is captured with the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h00000000;
    end else if (take && !hwrite) begin
      if (haddr[31:0] == {24'h000000, `PMS_OFS_CFG}) begin
        rdata_ff <= {27'h0000000, cfg_ff};
      end else if (haddr[31:0] == {24'h000000, `PMS_OFS_STATUS}) begin
        rdata_ff <= {28'h0000000, burst4_ff, vib_s2_ff, in_call_ff, busy_ff};
      end else begin
        rdata_ff <= 32'h00000000;
      end
    end
  end

  // ===================================================================
  // configuration and call state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= `PMS_CFG_RESET;
    end else if (wr_go && (addr_ff == `PMS_OFS_CFG)) begin
      cfg_ff <= hwdata[4:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_call_ff <= 1'b0;
    end else if (go_call) begin
      in_call_ff <= 1'b1;
    end else if (go_end) begin
      in_call_ff <= 1'b0;
    end
  end

  // correction mode of the current call
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst4_ff <= 1'b0;
    end else if (go_call) begin
      burst4_ff <= cfg_ff[`PMS_CFG_BURST] && hwdata[`PMS_CALL_RICB] &&
                   (hwdata[`PMS_CALL_FC2] == hwdata[`PMS_CALL_FC1]);
    end
  end
  assign corr_burst4 = burst4_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vib_s1_ff <= 1'b0;
      vib_s2_ff <= 1'b0;
    end else begin
      vib_s1_ff <= vib_enable;
      vib_s2_ff <= vib_s1_ff;
    end
  end

  // ===================================================================
  // word builder and handshake toward the link
  logic [23:0] word_ff;
  logic [4:0]  len_ff;
  logic        req_ff;
  logic        ack_s1_ff;
  logic        ack_s2_ff;
  logic        ack_s3_ff;
  logic        ack_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_ff <= 24'h000000;
      len_ff  <= `PMS_LEN_CMD;
    end else if (go_call) begin
      word_ff <= {16'h0000, hwdata[`PMS_CALL_FC2], hwdata[`PMS_CALL_FC1],
                  hwdata[`PMS_CALL_RICB],
                  cfg_ff[`PMS_CFG_OVB], cfg_ff[`PMS_CFG_OVA],
                  cfg_ff[`PMS_CFG_BURST],
                  2'b10};
      len_ff  <= `PMS_LEN_CMD;
    end else if (go_msg) begin
      word_ff <= {hwdata[21:2], 4'hF};
      len_ff  <= `PMS_LEN_MSG;
    end else if (go_end) begin
      word_ff <= {16'h0000, 2'b00, cfg_ff[`PMS_CFG_DBL],
                  cfg_ff[`PMS_CFG_USER],
                  !vib_s2_ff,
                  hwdata[`PMS_END_OK],
                  2'b00};
      len_ff  <= `PMS_LEN_CMD;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff <= 1'b0;
    end else if (go_call || go_msg || go_end) begin
      req_ff <= !req_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_s3_ff <= 1'b0;
    end else begin
      ack_s1_ff <= ack_ff;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_ff <= 1'b0;
    end else if (go_call || go_msg || go_end) begin
      busy_ff <= 1'b1;
    end else if (ack_s2_ff != ack_s3_ff) begin
      busy_ff <= 1'b0;
    end
  end

  // ===================================================================
  // link domain
  logic         lrst_s1_ff;
  logic         lrst_n_ff;
  logic         req_s1_ff;
  logic         req_s2_ff;
  logic         req_s3_ff;
  logic [23:0]  shift_ff;
  logic [4:0]   cnt_ff;
  logic         strobe_ff;
  pms_link_st_t lst_ff;

  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      lrst_s1_ff <= 1'b0;
      lrst_n_ff  <= 1'b0;
    end else begin
      lrst_s1_ff <= 1'b1;
      lrst_n_ff  <= lrst_s1_ff;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_s3_ff <= 1'b0;
    end else begin
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
    end
  end

  // word and length are held by the bus side until the ack returns
  always_ff @(posedge link_clk or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      lst_ff    <= PMS_L_IDLE;
      shift_ff  <= 24'h000000;
      cnt_ff    <= 5'h00;
      strobe_ff <= 1'b0;
      ack_ff    <= 1'b0;
    end else begin
      case (lst_ff)
        PMS_L_IDLE: begin
          if (req_s2_ff != req_s3_ff) begin
            shift_ff <= word_ff;
            cnt_ff   <= len_ff;
            lst_ff   <= PMS_L_LOW;
          end
        end
        PMS_L_LOW: begin
          strobe_ff <= 1'b1;
          lst_ff    <= PMS_L_HIGH;
        end
        PMS_L_HIGH: begin
          strobe_ff <= 1'b0;
          if (cnt_ff == 5'h01) begin
            ack_ff <= !ack_ff;
            lst_ff <= PMS_L_IDLE;
          end else begin
            shift_ff <= {1'b0, shift_ff[23:1]};
            cnt_ff   <= cnt_ff - 5'h01;
            lst_ff   <= PMS_L_LOW;
          end
        end
        default: begin
          lst_ff <= PMS_L_IDLE;
        end
      endcase
    end
  end

  assign ser_data   = shift_ff[0];
  assign ser_strobe = strobe_ff;

  // ===================================================================
  // checks
  a_start_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
    go_call |=> (word_ff[1:0] == 2'b10) && (len_ff == 5'h08))
    else $error("start word fixed bits wrong");

  a_start_cfg: assert property (@(posedge hclk) disable iff (!hresetn)
    go_call |=> word_ff[4:2] == {$past(cfg_ff[2]), $past(cfg_ff[1]), $past(cfg_ff[0])})
    else $error("start word settings wrong");

  a_start_ric: assert property (@(posedge hclk) disable iff (!hresetn)
    go_call |=> word_ff[5] == $past(hwdata[0]))
    else $error("start word code select wrong");

  a_start_func: assert property (@(posedge hclk) disable iff (!hresetn)
    go_call |=> word_ff[7:6] == $past(hwdata[21:20]))
    else $error("start word function bits wrong");

  a_msg_layout: assert property (@(posedge hclk) disable iff (!hresetn)
    go_msg |=> (word_ff == {$past(hwdata[21:2]), 4'hF}) && (len_ff == 5'h18))
    else $error("message word layout wrong");

  a_stop_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
    go_end |=> (word_ff[1:0] == 2'b00) && (word_ff[7:6] == 2'b00))
    else $error("stop word fixed bits wrong");

  a_stop_vib: assert property (@(posedge hclk) disable iff (!hresetn)
    go_end |=> word_ff[3] != $past(vib_s2_ff))
    else $error("stop word vibrator bit wrong");

  a_stop_ok: assert property (@(posedge hclk) disable iff (!hresetn)
    go_end |=> word_ff[2] == $past(hwdata[0]))
    else $error("stop word status bit wrong");

  a_call_launch: assert property (@(posedge hclk) disable iff (!hresetn)
    go_call |=> busy_ff && (req_ff != $past(req_ff)) && in_call_ff)
    else $error("call did not start a transfer");

  a_cmd_stall: assert property (@(posedge hclk) disable iff (!hresetn)
    busy_ff |-> !(go_call || go_msg || go_end))
    else $error("command taken while link busy");

  a_word_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    busy_ff |=> $stable(word_ff) && $stable(len_ff))
    else $error("link word changed while busy");

  a_stop_cfg: assert property (@(posedge hclk) disable iff (!hresetn)
    go_end |=> word_ff[5:4] == {$past(cfg_ff[4]), $past(cfg_ff[3])})
    else $error("stop word settings wrong");

  a_next_call: assert property (@(posedge hclk) disable iff (!hresetn)
    go_call && in_call_ff |=> in_call_ff && (word_ff[1:0] == 2'b10))
    else $error("second call did not open with a start word");

  a_burst_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    go_call && !cfg_ff[0] |=> !corr_burst4)
    else $error("burst correction chosen while disabled");

  a_strobe_pulse: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
    $rose(ser_strobe) |=> $fell(ser_strobe))
    else $error("strobe high time wrong");

  a_strobe_idle: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
    (lst_ff == PMS_L_IDLE) |-> !ser_strobe)
    else $error("strobe moved outside a word");

  a_data_hold: assert property (@(posedge link_clk) disable iff (!lrst_n_ff)
    ser_strobe |-> $stable(ser_data))
    else $error("data moved while strobe high");

  c_call: cover property (@(posedge hclk) disable iff (!hresetn) go_call);
  c_msg_word: cover property (@(posedge hclk) disable iff (!hresetn) go_msg);
  c_stall: cover property (@(posedge hclk) disable iff (!hresetn) !hreadyout);
  c_back2back: cover property (@(posedge hclk) disable iff (!hresetn)
    go_call && in_call_ff);
  c_word_done: cover property (@(posedge link_clk) disable iff (!lrst_n_ff)
    (lst_ff == PMS_L_HIGH) && (cnt_ff == 5'h01));

endmodule

`default_nettype wire

// ### verif/pms_link_rx.sv
// receiver model of the microcontroller side of the serial link
// assumes data and strobe come from registers clocked by link_clk
`timescale 1ns/10ps
`default_nettype none

module pms_link_rx (
  // link side
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic ser_data,
  input wire logic ser_strobe
);
  logic [31:0] words[$];
  int          ok_ends;
  logic [23:0] acc;
  logic [7:0]  cnt;
  logic        strobe_q;
  logic        open;
  int          idle;

  // =====================================================================
  // bit capture and word framing by idle gaps
  always @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      words.delete();
      ok_ends = 0;
      acc = 24'h0;
      cnt = 8'h0;
      strobe_q = 1'h0;
      open = 1'h0;
      idle = 0;
    end else begin
      // data is taken once the strobe has risen, while it is held
      if (ser_strobe && !strobe_q && cnt < 8'h18) begin
        acc[cnt[4:0]] = ser_data;
        cnt = cnt + 8'h1;
      end
      idle = ser_strobe ? 0 : idle + 1;
      strobe_q = ser_strobe;
      if (idle == 3 && cnt != 8'h0) begin
        // a start word inside an open message closes it as a success
        if (cnt == 8'h08 && acc[1:0] == 2'h2 && open) ok_ends++;
        if (cnt == 8'h08 && acc[1:0] == 2'h0 && acc[2]) ok_ends++;
        open = (cnt == 8'h08 && acc[1:0] == 2'h2) || (open && cnt == 8'h18);
        words.push_back({cnt, acc});
        cnt = 8'h0;
        acc = 24'h0;
      end
    end
  end
endmodule

`default_nettype wire

// ### verif/pager_message_serial_out_tb_top.sv
// bench top: seeded random calls over the register bus, link words
// compared as caught by the receiver model; one slave on the bus
`timescale 1ns/10ps
`default_nettype none
`include "pms_regs.svh"

module pager_message_serial_out_tb_top;
  logic        hclk = 1'h0;
  logic        link_clk = 1'h0;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        vib_enable;
  wire logic   hreadyout;
  wire logic   hresp;
  wire logic   ser_data;
  wire logic   ser_strobe;
  wire logic   corr_burst4;
  wire logic [31:0] hrdata;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          exp_ok = 0;
  logic [31:0] rnd_state = 32'h0000003C;
  logic [31:0] rd;
  logic [31:0] w;
  logic [31:0] call;
  logic [4:0]  cfg;
  logic        corr;
  logic        open;
  logic        ok;
  logic [31:0] exp_q[$];

  always #20 hclk = ~hclk;
  initial begin
    #7;
    forever begin
      link_clk = ~link_clk;
      #80;
    end
  end

  pms_serial_out pms_serial_out_i (
    .hclk(hclk), .hresetn(hresetn), .link_clk(link_clk), .hsel(1'h1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .vib_enable(vib_enable),
    .ser_data(ser_data), .ser_strobe(ser_strobe), .corr_burst4(corr_burst4)
  );

  pms_link_rx pms_link_rx_i (
    .link_clk(link_clk), .rst_n(hresetn), .ser_data(ser_data), .ser_strobe(ser_strobe)
  );

  // =====================================================================
  // helpers
  function automatic logic [31:0] xs();
    rnd_state = rnd_state ^ (rnd_state << 13);
    rnd_state = rnd_state ^ (rnd_state >> 17);
    rnd_state = rnd_state ^ (rnd_state << 5);
    return rnd_state;
  endfunction

  function automatic logic [31:0] start_w(input logic [4:0] c, input logic [31:0] k);
    return {8'h08, 16'h0, k[21], k[20], k[0], c[2:0], 2'h2};
  endfunction

  function automatic logic [31:0] stop_w(input logic [4:0] c, input logic s, input logic v);
    return {8'h08, 18'h0, c[4], c[3], ~v, s, 2'h0};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  // waits for the link to deliver every queued word, then compares
  task automatic drain(input logic [31:0] st);
    logic [31:0] g;
    for (int k = 0; k < 6000 && pms_link_rx_i.words.size() < exp_q.size(); k++)
      @(posedge hclk);
    while (exp_q.size() > 0) begin
      g = (pms_link_rx_i.words.size() > 0) ? pms_link_rx_i.words.pop_front() : 32'hX;
      if (exp_q[0][31:24] == 8'h08 && exp_q[0][1:0] == 2'h0) g[7:6] = 2'h0;
      check(g, exp_q.pop_front());
    end
    bus(1'h0, {24'h0, `PMS_OFS_STATUS}, 32'h0);
    check(rd, st);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    vib_enable = 1'h0;
    hresetn = 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (16) @(posedge hclk);
    bus(1'h0, {24'h0, `PMS_OFS_CFG}, 32'h0);
    check(rd, {27'h0, `PMS_CFG_RESET});
    bus(1'h1, 32'h00000100, 32'hFFFFFFFF);
    bus(1'h0, 32'h00000100, 32'h0);
    check(rd, 32'h0);
    open = 1'h0;
    for (int i = 0; i < 8; i++) begin
      w = xs();
      cfg = (i == 0) ? 5'h1F : w[4:0];
      call = xs();
      if (i == 0) call = call | 32'h00300001;
      vib_enable <= w[8];
      bus(1'h1, {24'h0, `PMS_OFS_CFG}, {27'h0, cfg});
      bus(1'h0, {24'h0, `PMS_OFS_CFG}, 32'h0);
      check(rd, {27'h0, cfg});
      if (open) exp_ok++;
      bus(1'h1, {24'h0, `PMS_OFS_CALL}, call);
      exp_q.push_back(start_w(cfg, call));
      corr = cfg[0] & call[0] & (call[21] == call[20]);
      @(posedge hclk);
      #1 check({31'h0, corr_burst4}, {31'h0, corr});
      // message words go back to back so the bus stalls on a busy link
      for (int j = 0; j < i % 3; j++) begin
        w = xs();
        exp_q.push_back({8'h18, w[21:2], 4'hF});
        bus(1'h1, {24'h0, `PMS_OFS_MSG}, w);
      end
      w = xs();
      ok = w[3];
      open = (i % 4 == 3);
      if (!open) begin
        bus(1'h1, {24'h0, `PMS_OFS_END}, {31'h0, ok});
        exp_q.push_back(stop_w(cfg, ok, vib_enable));
        if (ok) exp_ok++;
      end
      drain({28'h0, corr, vib_enable, open, 1'h0});
    end
    check(32'(pms_link_rx_i.words.size()), 32'h0);
    check(32'(pms_link_rx_i.ok_ends), 32'(exp_ok));
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge hclk);
    n_fail++;
    finish_test();
  end
endmodule

`default_nettype wire
